// *** dram_model.sv ***
// DRAM side stand-in: takes prefetches, returns line data in order, paces writes.
// Assumes one clock; slow mode stalls both paths part of the time.
`timescale 1ns/1ps
`default_nettype none
module dram_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Pace select
	input wire logic slow,
	// Prefetch path
	input wire train_pkg::rd_req_t pf_req,
	output logic pf_ready,
	output logic pf_data_valid,
	output logic [63:0] pf_data,
	// Write channel
	output logic ch_ready
);
	logic [31:0] q[$];
	logic [2:0] cnt_r;
	// Data carries its line address, so order slips show; idle data toggles
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_r <= 3'h0;
			pf_ready <= 1'b0;
			ch_ready <= 1'b0;
			pf_data_valid <= 1'b0;
			pf_data <= 64'h0;
			q.delete();
		end
		else
		begin
			cnt_r <= cnt_r + 3'h1;
			pf_ready <= !slow || cnt_r[1];
			ch_ready <= !slow || cnt_r[0];
			if (pf_req.valid === 1'b1)
				q.push_back(pf_req.addr);
			if (q.size() > 0 && (!slow || cnt_r[2]))
			begin
				pf_data_valid <= 1'b1;
				pf_data <= {q[0], ~q[0]};
				q.pop_front();
			end
			else
			begin
				pf_data_valid <= 1'b0;
				pf_data <= ~pf_data;
			end
		end
	end
endmodule : dram_model
`default_nettype wire

// *** dram_training_traffic_gen.sv ***
// DRAM training traffic generator: prefetch training mode and write bursting with APB registers.
// Assumes core reads and DRAM returns on the same clock as the APB bus.
//
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module dram_training_traffic_gen #(
	parameter int BUF_DEPTH = 32,
	parameter int BUF_AW = 5
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Core reads
	input wire train_pkg::rd_req_t rd_req,
	output train_pkg::rd_rsp_t rd_rsp,
	// DRAM prefetch reads
	output train_pkg::rd_req_t pf_req,
	input wire logic pf_ready,
	input wire logic pf_data_valid,
	input wire logic [63:0] pf_data,
	// Writes
	input wire train_pkg::wr_req_t wr_in,
	output logic wr_ready,
	output train_pkg::wr_req_t wr_out,
	input wire logic ch_ready,
	// Latency setting out to the read path
	output logic [9:0] max_read_latency
);
	typedef enum logic [1:0] {PF_IDLE, PF_SEEN, PF_RUN} pf_state_t;
	pf_state_t state_r;
	logic train_r;
	logic flush_pulse_r;
	logic [1:0] leak_r;
	logic [7:0] wlim_r;
	logic [7:0] plim_r;
	logic [9:0] lat_r;
	logic [31:0] last_addr_r;
	logic [31:0] next_addr_r;
	logic [7:0] issued_r;
	logic [7:0] filled_r;
	logic [31:0] base_r;
	logic [63:0] buf_mem [BUF_DEPTH];
	logic flush_busy;
	// Stride check: next line and same 4 KB page
	function automatic logic is_stride(input logic [31:0] prev, input logic [31:0] cur);
		is_stride = (cur == prev + train_pkg::LINE_BYTES) &&
			((cur & train_pkg::PAGE_MASK) == (prev & train_pkg::PAGE_MASK));
	endfunction : is_stride
	// APB decode
	wire acc = psel && penable;
	wire wr_cfg = acc && pwrite && (paddr == train_pkg::CFG_OFS);
	wire wr_lat = acc && pwrite && (paddr == train_pkg::LAT_OFS);
	wire mapped = (paddr == train_pkg::CFG_OFS) || (paddr == train_pkg::STAT_OFS) || (paddr == train_pkg::LAT_OFS);
	wire set_train = wr_cfg && pwdata[train_pkg::TRAIN_BIT];
	wire clr_train = wr_cfg && !pwdata[train_pkg::TRAIN_BIT];
	wire pf_fire = (state_r == PF_RUN) && pf_ready && (issued_r != plim_r);
	wire pf_done = (state_r == PF_RUN) && (issued_r == plim_r);
	wire [31:0] cfg_val = {12'h000, plim_r, wlim_r, leak_r, flush_busy, train_r};
	wire [31:0] stat_val = {22'h000000, 8'h00, flush_busy, train_r};
	wire [31:0] rd_val = (paddr == train_pkg::CFG_OFS) ? cfg_val :
		(paddr == train_pkg::STAT_OFS) ? stat_val :
		(paddr == train_pkg::LAT_OFS) ? {22'h000000, lat_r} : 32'h00000000;
	// Buffer lookup for later strided reads
	wire [31:0] rd_off = rd_req.addr - base_r;
	wire [31:0] rd_line = rd_off >> 6;
	wire buf_hit = (state_r != PF_RUN) && (rd_line < {24'h000000, filled_r}) && (rd_off[5:0] == 6'h00)
		&& (rd_line < BUF_DEPTH);
	assign pready = 1'b1;
	assign pslverr = acc && !mapped;
	assign max_read_latency = lat_r;
	// APB registers
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			leak_r <= train_pkg::LEAK_RST;
			wlim_r <= train_pkg::WLIM_RST;
			plim_r <= train_pkg::PLIM_RST;
			lat_r <= train_pkg::LAT_RST;
			flush_pulse_r <= 1'b0;
			prdata <= '0;
		end
		else
		begin
			flush_pulse_r <= wr_cfg && pwdata[train_pkg::FLUSH_BIT];
			if (wr_cfg)
			begin
				leak_r <= pwdata[train_pkg::LEAK_LO +: 2];
				wlim_r <= pwdata[train_pkg::WLIM_LO +: 8];
				plim_r <= pwdata[train_pkg::PLIM_LO +: 8];
			end
			if (wr_lat)
				lat_r <= pwdata[9:0];
			if (psel && !penable && !pwrite)
				prdata <= rd_val;
		end
	end
	// Training mode bit: software sets or clears, hardware clears at the limit
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			train_r <= 1'b0;
		else if (set_train)
			train_r <= 1'b1;
		else if (clr_train || pf_done)
			train_r <= 1'b0;
	end
	// Stride predictor and prefetch issue
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_r <= PF_IDLE;
			last_addr_r <= '0;
			next_addr_r <= '0;
			issued_r <= '0;
			base_r <= '0;
		end
		else if (set_train)
		begin
			state_r <= PF_SEEN;
			last_addr_r <= '0;
			issued_r <= '0;
		end
		else
		begin
			case (state_r)
				PF_SEEN:
					if (rd_req.valid && train_r)
					begin
						last_addr_r <= rd_req.addr;
						if (issued_r == 8'h01 && is_stride(last_addr_r, rd_req.addr))
						begin
							state_r <= PF_RUN;
							base_r <= last_addr_r;
							next_addr_r <= last_addr_r;
							issued_r <= '0;
						end
						else
							issued_r <= 8'h01;
					end
				PF_RUN:
					if (pf_done)
						state_r <= PF_IDLE;
					else if (pf_fire)
					begin
						issued_r <= issued_r + 8'h01;
						next_addr_r <= next_addr_r + train_pkg::LINE_BYTES;
					end
				default:
					state_r <= state_r;
			endcase
		end
	end
	// Prefetch request, registered; the two seed reads are refetched too
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			pf_req <= '0;
		else
		begin
			pf_req.valid <= pf_fire;
			pf_req.addr <= next_addr_r;
		end
	end
	// Prefetch data capture in order of return
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			filled_r <= '0;
		else if (set_train)
			filled_r <= '0;
		else if (pf_data_valid && filled_r < BUF_DEPTH)
			filled_r <= filled_r + 8'h01;
	end
	always_ff @(posedge clk)
	begin
		if (pf_data_valid && filled_r < BUF_DEPTH)
			buf_mem[filled_r[BUF_AW-1:0]] <= pf_data;
	end
	// Read answer from the prefetch buffer
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rd_rsp <= '0;
		else
		begin
			rd_rsp.valid <= rd_req.valid;
			rd_rsp.hit <= rd_req.valid && buf_hit;
			rd_rsp.data <= buf_mem[rd_line[BUF_AW-1:0]];
		end
	end
	// Write burst path
	write_burst #(.DEPTH(16), .AW(4)) u_wb (
		.clk(clk),
		.rst_n(rst_n),
		.leak_limit(leak_r),
		.burst_limit(wlim_r),
		.flush_req(flush_pulse_r),
		.flush_busy(flush_busy),
		.wr_in(wr_in),
		.wr_ready(wr_ready),
		.wr_out(wr_out),
		.ch_ready(ch_ready)
	);
	sequence s_set;
		set_train;
	endsequence
	a_flush_table: assert property (@(posedge clk) disable iff (!rst_n)
		s_set |=> state_r == PF_SEEN && issued_r == 8'h00) else $error("predictor not flushed");
	a_limit_clear: assert property (@(posedge clk) disable iff (!rst_n)
		pf_done && !set_train |=> !train_r) else $error("mode not cleared at limit");
	a_count_limit: assert property (@(posedge clk) disable iff (!rst_n)
		state_r == PF_RUN |-> issued_r <= plim_r) else $error("prefetch over limit");
	a_status_live: assert property (@(posedge clk) disable iff (!rst_n)
		psel && !penable && !pwrite && paddr == train_pkg::STAT_OFS
		|=> prdata == {30'h0, $past(flush_busy), $past(train_r)}) else $error("status not live");
	a_flush_start: assert property (@(posedge clk) disable iff (!rst_n)
		wr_cfg && pwdata[train_pkg::FLUSH_BIT] |=> ##1 flush_busy) else $error("flush not started");
	a_hit_needs: assert property (@(posedge clk) disable iff (!rst_n)
		rd_rsp.hit |-> $past(filled_r) != 8'h00) else $error("hit with empty buffer");
	a_pf_addr: assert property (@(posedge clk) disable iff (!rst_n)
		pf_fire ##1 pf_fire |-> ##1 pf_req.addr == $past(pf_req.addr) + train_pkg::LINE_BYTES)
		else $error("prefetch stride broken");
	a_apb_err: assert property (@(posedge clk) disable iff (!rst_n)
		acc && !mapped |-> pslverr && (pwrite || prdata == 32'h00000000)) else $error("unmapped not flagged");
endmodule : dram_training_traffic_gen
`default_nettype wire

// *** tb_dram_training_traffic_gen.sv ***
// Self-checking bench: APB host, core reads and a write stream.
// Assumes dram_model stands in for the DRAM side.
`timescale 1ns/1ps
`default_nettype none
module tb_dram_training_traffic_gen;
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr, pf_ready, pf_data_valid, wr_ready, ch_ready, slow, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, seed, r, a;
	logic [63:0] pf_data;
	logic [9:0] max_read_latency;
	logic [64:0] rn;
	logic [95:0] wn;
	train_pkg::rd_req_t rd_req, pf_req;
	train_pkg::rd_rsp_t rd_rsp;
	train_pkg::wr_req_t wr_in, wr_out;
	logic [64:0] rq[$];
	logic [95:0] wq[$];
	int n_errors, tests_run, n_out, b;
	dram_training_traffic_gen #(.BUF_DEPTH(32), .BUF_AW(5)) i_dut (.clk, .rst_n, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .rd_req, .rd_rsp, .pf_req, .pf_ready, .pf_data_valid,
		.pf_data, .wr_in, .wr_ready, .wr_out, .ch_ready, .max_read_latency);
	dram_model i_mem (.clk, .rst_n, .slow, .pf_req, .pf_ready, .pf_data_valid, .pf_data, .ch_ready);
	// 200 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	function automatic logic [31:0] cfg(input logic t, input logic f, input logic [7:0] wl, input logic [7:0] pl);
		return {12'h000, pl, wl, train_pkg::LEAK_NONE, f, t};
	endfunction : cfg
	task automatic stop_test();
		$display("tests %0d errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : stop_test
	// Wide enough for a whole write word, address and data together
	task automatic chk(input string nm, input logic [95:0] x, input logic [95:0] g);
		tests_run++;
		if (g !== x)
		begin
			n_errors++;
			$display("unexpected %s exp %h got %h", nm, x, g);
		end
	endtask : chk
	task automatic hang(input int n);
		if (n >= 200)
		begin
			n_errors++;
			stop_test();
		end
	endtask : hang
	// Setup then access; request held until pready is seen at an edge
	task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		penable <= 1'b0;
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 200);
		r = prdata;
		e = pslverr;
		hang(n);
		psel <= 1'b0;
		penable <= 1'b0;
		// One idle edge, so a following call never redrives psel in this step
		@(posedge clk);
	endtask : apb
	task automatic poll(input int bt);
		int n;
		n = 0;
		do
		begin
			apb(1'b0, train_pkg::STAT_OFS, 32'h0);
			n++;
		end
		while (r[bt] !== 1'b0 && n < 200);
		hang(n);
	endtask : poll
	// Wait for DRAM returns to drain and the write count to land
	task automatic settle(input int want);
		int n;
		n = 0;
		while ((i_mem.q.size() != 0 || pf_data_valid || n_out != want) && n < 200)
		begin
			@(posedge clk);
			n++;
		end
		hang(n);
	endtask : settle
	task automatic rd(input logic [31:0] ad, input logic h);
		rq.push_back({h, ad, ~ad});
		rd_req <= '{1'b1, ad};
		@(posedge clk);
		rd_req.valid <= 1'b0;
		@(posedge clk);
	endtask : rd
	task automatic wr(input logic [31:0] ad);
		int n;
		logic [63:0] d;
		n = 0;
		d = {xs(), xs()};
		wq.push_back({ad, d});
		wr_in <= '{1'b1, ad, d};
		do
		begin
			@(negedge clk);
			n++;
		end
		while (wr_ready !== 1'b1 && n < 200);
		@(posedge clk);
		hang(n);
		wr_in.valid <= 1'b0;
		@(posedge clk);
	endtask : wr
	// Each result takes the oldest note; a result with no note mismatches on x
	always @(negedge clk)
	begin
		if (rst_n && rd_rsp.valid === 1'b1)
		begin
			rn = rq.size() ? rq.pop_front() : 'x;
			chk("rd hit", rn[64], rd_rsp.hit);
			if (rn[64])
				chk("rd data", rn[63:0], rd_rsp.data);
		end
		if (rst_n && wr_out.valid === 1'b1)
		begin
			wn = wq.size() ? wq.pop_front() : 'x;
			n_out++;
			chk("wr word", wn, {wr_out.addr, wr_out.data});
		end
	end
	// Main sequence
	initial
	begin
		{seed, rst_n, psel, penable, pwrite, paddr, pwdata, slow} = {32'h00015ACE, 49'h0}; // Seed 88782
		rd_req = '0;
		wr_in = '0;
		{n_errors, tests_run, n_out} = '0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		apb(1'b0, train_pkg::CFG_OFS, 32'h0);
		chk("cfg reset", {12'h0, train_pkg::PLIM_RST, train_pkg::WLIM_RST, train_pkg::LEAK_RST, 2'h0}, r);
		apb(1'b0, train_pkg::STAT_OFS, 32'h0);
		chk("stat reset", 64'h0, r);
		apb(1'b1, 12'h0FC, 32'hFFFFFFFF);
		chk("slverr", 64'h1, e);
		apb(1'b0, 12'h0FC, 32'h0);
		chk("unmapped", 64'h0, r);
		a = xs();
		apb(1'b1, train_pkg::LAT_OFS, a);
		apb(1'b0, train_pkg::LAT_OFS, 32'h0);
		chk("lat", a[9:0], r);
		chk("lat out", a[9:0], max_read_latency);
		$display("test registers done");
		for (int s = 0; s < 2; s++)
		begin
			slow <= s[0];
			a = xs() & 32'hFFFFF7C0;
			apb(1'b1, train_pkg::CFG_OFS, cfg(1'b1, 1'b0, 8'h10, 8'h06));
			apb(1'b0, train_pkg::STAT_OFS, 32'h0);
			chk("train held", 64'h1, r[0]);
			rd(a, 1'b0);
			rd(a + train_pkg::LINE_BYTES, 1'b0);
			poll(0);
			settle(n_out);
			for (int k = 2; k < 6; k++)
				rd(a + train_pkg::LINE_BYTES * k, 1'b1);
			$display("test prefetch set %0d done", s);
		end
		apb(1'b1, train_pkg::CFG_OFS, cfg(1'b0, 1'b1, 8'h04, 8'h00));
		poll(1);
		b = n_out;
		for (int k = 0; k < 3; k++)
			wr(a + train_pkg::LINE_BYTES * k);
		repeat (20) @(posedge clk);
		chk("held", b, n_out);
		wr(a + 32'h000000C0);
		settle(b + 4);
		chk("burst", b + 4, n_out);
		wr(a);
		wr(a + train_pkg::LINE_BYTES);
		apb(1'b1, train_pkg::CFG_OFS, cfg(1'b0, 1'b1, 8'h04, 8'h00));
		// Two writes still held, so the flush bit must read back as busy
		apb(1'b0, train_pkg::STAT_OFS, 32'h0);
		chk("flush live", 64'h1, r[1]);
		poll(1);
		settle(b + 6);
		chk("flushed", b + 6, n_out);
		$display("test write burst done");
		stop_test();
	end
endmodule : tb_dram_training_traffic_gen
`default_nettype wire

// *** train_pkg.sv ***
// Package for the DRAM training traffic generator: register map, field layout, reset values,
// request and answer carriers.
// Assumes a 32-bit APB slave and single-clock logic.
// Overview of operation
// - Setting training mode flushes the stride predictor table.
// - After stride detection, prefetch back to back until limit, then clear mode.
// - Prefetched data is held and serves later reads to strided addresses.
// - With leak limit 00b, writes below the burst watermark are not forwarded.
// - Write flush drains pending writes and self-clears when finished.
// - Held writes go out as one burst at the limit or on a new flush.
package train_pkg;
	localparam logic [11:0] CFG_OFS = 12'h000;
	localparam logic [11:0] STAT_OFS = 12'h004;
	localparam logic [11:0] LAT_OFS = 12'h008;
	// Control register field positions
	localparam int TRAIN_BIT = 0;
	localparam int FLUSH_BIT = 1;
	localparam int LEAK_LO = 2;
	localparam int WLIM_LO = 4;
	localparam int PLIM_LO = 12;
	localparam logic [1:0] LEAK_NONE = 2'h0;
	localparam logic [7:0] WLIM_RST = 8'h10;
	localparam logic [7:0] PLIM_RST = 8'h00;
	localparam logic [1:0] LEAK_RST = 2'h3;
	localparam logic [9:0] LAT_RST = 10'h000;
	localparam logic [31:0] LINE_BYTES = 32'h00000040;
	localparam logic [31:0] PAGE_MASK = 32'hFFFFF000;
	// Core-side read request and answer
	typedef struct packed {
		logic valid;
		logic [31:0] addr;
	} rd_req_t;
	typedef struct packed {
		logic valid;
		logic hit;
		logic [63:0] data;
	} rd_rsp_t;
	// Write request
	typedef struct packed {
		logic valid;
		logic [31:0] addr;
		logic [63:0] data;
	} wr_req_t;
endpackage : train_pkg

// *** write_burst.sv ***
// Write burst gatherer: holds streamed writes and releases them as one burst.
// Assumes the channel side accepts a write whenever ch_ready is high.
`timescale 1ns/1ps
`default_nettype none
module write_burst #(
	parameter int DEPTH = 16,
	parameter int AW = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Control
	input wire logic [1:0] leak_limit,
	input wire logic [7:0] burst_limit,
	input wire logic flush_req,
	output logic flush_busy,
	// Incoming writes
	input wire train_pkg::wr_req_t wr_in,
	output logic wr_ready,
	// Channel side
	output train_pkg::wr_req_t wr_out,
	input wire logic ch_ready
);
	train_pkg::wr_req_t mem [DEPTH];
	logic [AW:0] count_r;
	logic [AW-1:0] rd_r;
	logic [AW-1:0] wr_r;
	logic drain_r;
	logic flush_r;
	wire hold_all = (leak_limit == train_pkg::LEAK_NONE);
	wire full = (count_r == (AW+1)'(DEPTH));
	wire at_limit = ({1'b0, count_r} >= {1'b0, burst_limit[AW:0]}) && (count_r != '0);
	wire can_pop = (count_r != '0) && ch_ready && (drain_r || !hold_all);
	wire push = wr_in.valid && wr_ready;
	assign wr_ready = !full && !flush_r;
	assign flush_busy = flush_r;
	// Pointers and count
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			count_r <= '0;
			rd_r <= '0;
			wr_r <= '0;
		end
		else
		begin
			if (push)
				mem[wr_r] <= wr_in;
			wr_r <= wr_r + AW'(push);
			rd_r <= rd_r + AW'(can_pop);
			count_r <= count_r + (AW+1)'(push) - (AW+1)'(can_pop);
		end
	end
	// Burst release: writes below the watermark stay held when leaking is off
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			drain_r <= 1'b0;
			flush_r <= 1'b0;
		end
		else
		begin
			if (flush_req || (hold_all && at_limit))
				drain_r <= 1'b1;
			else if (count_r == '0 || (count_r == 1 && can_pop))
				drain_r <= 1'b0;
			if (flush_req)
				flush_r <= 1'b1;
			else if (count_r == '0 || (count_r == 1 && can_pop))
				flush_r <= 1'b0;
		end
	end
	// Output register stage
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			wr_out <= '0;
		else
		begin
			wr_out <= mem[rd_r];
			wr_out.valid <= can_pop;
		end
	end
	a_hold_below: assert property (@(posedge clk) disable iff (!rst_n)
		hold_all && !drain_r && !flush_req |=> !wr_out.valid) else $error("write leaked below watermark");
	a_flush_clear: assert property (@(posedge clk) disable iff (!rst_n)
		flush_r && count_r == '0 && !flush_req |=> !flush_r) else $error("flush did not self clear");
endmodule : write_burst
`default_nettype wire
